// ---- logic/snpc_pairing_ctrl.v ----
// Pairing sequencer with its host register file and permitted-node table.
// Functional notes
// - New identity goes to lowest free entry.
// - Client wakes listening master, then sends frame.
// - Insert only absent identity with good checksum.
// - Client returns to standby after handshake; master keeps listening.
// - Temporary pairing listens, adds, adopts timing, silent; with the master bit clear it sends the wake call and data frame.
// - Wakeup interval from wakeup config bits 4:2.
// - Main bit two enables wakeup detection.
// - Master sends wakeup pattern for configured duration.
// - Client period code carried in data frame.
// - Client random offset carried in data frame.
// - Rate field sets link rate, equal both ends.
// - Permitted-node table spans main 0x08 to 0x1F.
// - Payload follows identity and timing fields.
// - Woken client sends five payload bytes; here waking only sets the woken flag, bytes go on send.
// - Master receives immediately after wakeup call.
// - Master replies sync, awaits ack, keeps listening.
// - Wakeup receiver listens 250 us each cycle.
// - Unknown good identity raises flag, no reply, when auto-insert and temporary mode are off.
// - Known identity with bad checksum gets nothing.
`timescale 1ns/1ps
`include "snpc_defs.vh"
module snpc_pairing_ctrl #(
  parameter [31:0] WAKE_CALL_CYC = `SNPC_WAKE_CALL_CYC,
  parameter [31:0] RX_LISTEN_CYC = `SNPC_RX_LISTEN_CYC,
  parameter [31:0] WAKE_CYC_BASE = `SNPC_WAKE_CYC_BASE_CYC,
  parameter [31:0] REPLY_WAIT_CYC = `SNPC_REPLY_WAIT_CYC
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [5:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  input wire i_ook_detect,
  input wire i_rx_valid,
  input wire [1:0] i_rx_type,
  input wire [23:0] i_rx_id,
  input wire [7:0] i_rx_timing,
  input wire [1:0] i_rx_rate,
  input wire i_rx_crc_ok,
  output reg o_ook_tx,
  output reg o_wake_listen,
  output reg o_rx_enable,
  output reg o_tx_valid,
  output reg [1:0] o_tx_type,
  output reg [23:0] o_tx_id,
  output reg [7:0] o_tx_timing,
  output reg [39:0] o_tx_payload,
  output reg [1:0] o_tx_rate,
  output reg o_unknown_node_irq
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAKE_TX = 3'h1;
  localparam [2:0] ST_LISTEN = 3'h2;
  localparam [2:0] ST_REPLY = 3'h3;
  localparam [2:0] ST_DET = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;
  localparam [2:0] ST_ACTIVE = 3'h6;
  localparam [2:0] ST_CL_WAIT = 3'h7;
  localparam [31:0] LISTEN_CYC = `SNPC_WAKE_LISTEN_CYC;

  reg [7:0] main_reg;
  reg [7:0] timer_en_reg;
  reg [7:0] listen_reg;
  reg [7:0] wake_cfg_reg;
  reg [7:0] rate_reg;
  reg [7:0] shadow_reg;
  reg [7:0] tbl_reg [0:23];
  reg [23:0] own_id_reg;
  reg [23:0] cand_reg;
  reg [7:0] pay_reg [0:4];
  reg [7:0] last_tim_reg;
  reg [4:0] stat_reg;
  reg [2:0] state_reg;
  reg [31:0] cnt_reg;
  reg [31:0] lcnt_reg;
  reg [23:0] pend_id_reg;
  reg ook_meta_reg;
  reg ook_sync_reg;
  reg hit;
  reg free_ok;
  reg [2:0] free_idx;
  reg [2:0] next_state;
  reg [4:0] clr;
  integer k, m;

  // Three consecutive bytes of a table entry form one 24-bit identity.
  function [4:0] base_of;
    input [2:0] n;
    begin
      base_of = {1'b0, n, 1'b0} + {2'b00, n};
    end
  endfunction

  function [23:0] id_of;
    input [2:0] n;
    reg [4:0] b;
    begin
      b = base_of(n);
      id_of = {tbl_reg[b], tbl_reg[b + 5'h01], tbl_reg[b + 5'h02]};
    end
  endfunction

  wire is_master = main_reg[`SNPC_MAIN_MASTER];
  wire shadow_sel = main_reg[`SNPC_MAIN_SHADOW];
  wire [31:0] wake_ivl = WAKE_CYC_BASE << wake_cfg_reg[4:2];
  // Duration code counts quarters of the full call, so code 3 is the full call.
  wire [31:0] call_len = (WAKE_CALL_CYC >> 2) * {30'h0000_0000, wake_cfg_reg[1:0]}
                         + (WAKE_CALL_CYC >> 2);
  wire wr_tbl = i_reg_wr && (i_reg_addr >= `SNPC_ADDR_TBL_LO) &&
                (i_reg_addr <= `SNPC_ADDR_TBL_HI) &&
                !(shadow_sel && i_reg_addr == `SNPC_ADDR_SHADOW);
  wire [4:0] tbl_wi = i_reg_addr[4:0] - 5'h08;
  wire rx_data = (state_reg == ST_LISTEN) && i_rx_valid &&
                 (i_rx_type == `SNPC_FRM_DATA) && (i_rx_id != 24'h00_0000);
  // Pairing refuses to start while any timer is still enabled.
  wire start_ok = (state_reg == ST_IDLE) && (timer_en_reg == 8'h00);
  wire start_cmd = i_reg_wr && (i_reg_addr == `SNPC_ADDR_MAIN) &&
                   i_reg_wdata[`SNPC_MAIN_START];
  wire send_cmd = i_reg_wr && (i_reg_addr == `SNPC_ADDR_MAIN) &&
                  i_reg_wdata[`SNPC_MAIN_SEND];
  wire listen_done = (lcnt_reg >= RX_LISTEN_CYC - 32'h0000_0001) &&
                     !listen_reg[`SNPC_LISTEN_EXT];

  always @*
  begin
    hit = 1'b0;
    free_ok = 1'b0;
    free_idx = 3'h0;
    // Descending scan leaves the lowest free entry selected.
    for (k = 7; k >= 0; k = k - 1)
    begin
      if (id_of(k[2:0]) == i_rx_id)
        hit = 1'b1;
      if (id_of(k[2:0]) == 24'h00_0000)
      begin
        free_ok = 1'b1;
        free_idx = k[2:0];
      end
    end
  end

  always @*
  begin
    next_state = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_cmd && start_ok)
          next_state = (i_reg_wdata[`SNPC_MAIN_TEMP] && i_reg_wdata[`SNPC_MAIN_MASTER]) ?
                       ST_LISTEN : ST_WAKE_TX;
        else if (send_cmd && start_ok && !is_master)
          next_state = ST_CL_WAIT;
        else if (main_reg[`SNPC_MAIN_WAKE_DET])
          next_state = ST_DET;
      ST_WAKE_TX:
        if (cnt_reg >= call_len - 32'h0000_0001)
          next_state = is_master ? ST_LISTEN : ST_CL_WAIT;
      ST_LISTEN:
        if (listen_done)
          next_state = ST_IDLE;
        else if (rx_data && i_rx_crc_ok && !main_reg[`SNPC_MAIN_TEMP] &&
                 (hit || (main_reg[`SNPC_MAIN_AUTO_INS] && free_ok)))
          next_state = ST_REPLY;
      ST_REPLY:
        if (i_rx_valid && i_rx_type == `SNPC_FRM_ACK && i_rx_id == pend_id_reg)
          next_state = ST_LISTEN;
        else if (cnt_reg >= REPLY_WAIT_CYC - 32'h0000_0001)
          next_state = ST_LISTEN;
      ST_DET:
        if (!main_reg[`SNPC_MAIN_WAKE_DET])
          next_state = ST_IDLE;
        else if (ook_sync_reg)
          next_state = ST_ACTIVE;
        else if (cnt_reg >= LISTEN_CYC - 32'h0000_0001)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (!main_reg[`SNPC_MAIN_WAKE_DET])
          next_state = ST_IDLE;
        else if (cnt_reg >= wake_ivl - 32'h0000_0001)
          next_state = ST_DET;
      ST_ACTIVE:
        if (!ook_sync_reg)
          next_state = is_master ? ST_LISTEN : ST_IDLE;
        else if (cnt_reg >= (wake_ivl << 1) + wake_ivl - 32'h0000_0001)
          next_state = ST_IDLE;
      ST_CL_WAIT:
        if (i_rx_valid && i_rx_type == `SNPC_FRM_SYNC && i_rx_id == own_id_reg)
          next_state = ST_IDLE;
        else if (cnt_reg >= REPLY_WAIT_CYC - 32'h0000_0001)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @*
  begin
    clr = 5'h00;
    if (i_reg_wr && i_reg_addr == `SNPC_ADDR_STATUS)
      clr = i_reg_wdata[4:0];
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      main_reg <= 8'h00;
      timer_en_reg <= 8'h00;
      listen_reg <= 8'h00;
      wake_cfg_reg <= 8'h00;
      rate_reg <= 8'h00;
      shadow_reg <= 8'h00;
      own_id_reg <= 24'h00_0000;
      cand_reg <= 24'h00_0000;
      last_tim_reg <= 8'h00;
      stat_reg <= 5'h00;
      state_reg <= ST_IDLE;
      cnt_reg <= 32'h0000_0000;
      lcnt_reg <= 32'h0000_0000;
      pend_id_reg <= 24'h00_0000;
      ook_meta_reg <= 1'b0;
      ook_sync_reg <= 1'b0;
      o_reg_rdata <= 8'h00;
      o_ook_tx <= 1'b0;
      o_wake_listen <= 1'b0;
      o_rx_enable <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_type <= 2'h0;
      o_tx_id <= 24'h00_0000;
      o_tx_timing <= 8'h00;
      o_tx_payload <= 40'h00_0000_0000;
      o_tx_rate <= 2'h0;
      o_unknown_node_irq <= 1'b0;
      for (m = 0; m < 24; m = m + 1)
        tbl_reg[m] <= 8'h00;
      for (m = 0; m < 5; m = m + 1)
        pay_reg[m] <= 8'h00;
    end
    else
    begin
      ook_meta_reg <= i_ook_detect;
      ook_sync_reg <= ook_meta_reg;
      state_reg <= next_state;
      cnt_reg <= (next_state != state_reg) ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
      if (next_state == ST_LISTEN && state_reg != ST_LISTEN && state_reg != ST_REPLY)
        lcnt_reg <= 32'h0000_0000;
      else if (state_reg == ST_LISTEN || state_reg == ST_REPLY)
        lcnt_reg <= lcnt_reg + 32'h0000_0001;
      o_ook_tx <= (next_state == ST_WAKE_TX);
      o_wake_listen <= (next_state == ST_DET) || (next_state == ST_ACTIVE);
      o_rx_enable <= (next_state == ST_LISTEN) || (next_state == ST_REPLY) ||
                     (next_state == ST_CL_WAIT);
      o_tx_rate <= rate_reg[1:0];
      o_unknown_node_irq <= stat_reg[`SNPC_ST_UNKNOWN];
      o_tx_valid <= 1'b0;
      if (i_reg_wr)
      begin
        case (i_reg_addr)
          `SNPC_ADDR_MAIN: main_reg <= i_reg_wdata & 8'hBD;
          `SNPC_ADDR_TIMER_EN: timer_en_reg <= i_reg_wdata;
          `SNPC_ADDR_LISTEN: listen_reg <= i_reg_wdata;
          `SNPC_ADDR_WAKE_CFG: wake_cfg_reg <= i_reg_wdata;
          `SNPC_ADDR_RATE: rate_reg <= i_reg_wdata;
          `SNPC_ADDR_OWN_ID0: own_id_reg[23:16] <= i_reg_wdata;
          `SNPC_ADDR_OWN_ID1: own_id_reg[15:8] <= i_reg_wdata;
          `SNPC_ADDR_OWN_ID2: own_id_reg[7:0] <= i_reg_wdata;
          default: ;
        endcase
        if (shadow_sel && i_reg_addr == `SNPC_ADDR_SHADOW)
          shadow_reg <= i_reg_wdata;
        if (wr_tbl)
          tbl_reg[tbl_wi] <= i_reg_wdata;
        if (i_reg_addr >= `SNPC_ADDR_PAY_LO && i_reg_addr <= `SNPC_ADDR_PAY_HI)
          pay_reg[i_reg_addr[2:0]] <= i_reg_wdata;
      end
      // Hardware events are applied after the clear, so a set in the same cycle wins.
      stat_reg[3:0] <= stat_reg[3:0] & ~clr[3:0];
      stat_reg[`SNPC_ST_BUSY] <= (next_state != ST_IDLE);
      if (state_reg == ST_ACTIVE && !ook_sync_reg)
        stat_reg[`SNPC_ST_WOKEN] <= 1'b1;
      // Client side: data frame after the call or on the host send command.
      if ((state_reg == ST_WAKE_TX || state_reg == ST_IDLE) && next_state == ST_CL_WAIT)
      begin
        o_tx_valid <= 1'b1;
        o_tx_type <= `SNPC_FRM_DATA;
        o_tx_id <= own_id_reg;
        o_tx_timing <= shadow_reg;
        o_tx_payload <= {pay_reg[0], pay_reg[1], pay_reg[2], pay_reg[3], pay_reg[4]};
      end
      // Client answers the master's sync frame with its acknowledgement.
      if (state_reg == ST_CL_WAIT && next_state == ST_IDLE && i_rx_valid &&
          i_rx_type == `SNPC_FRM_SYNC)
      begin
        o_tx_valid <= 1'b1;
        o_tx_type <= `SNPC_FRM_ACK;
        o_tx_id <= own_id_reg;
        stat_reg[`SNPC_ST_PAIRED] <= 1'b1;
      end
      if (state_reg == ST_REPLY && next_state == ST_LISTEN && i_rx_valid)
        stat_reg[`SNPC_ST_PAIRED] <= 1'b1;
      if (rx_data && i_rx_crc_ok)
      begin
        if (main_reg[`SNPC_MAIN_TEMP])
        begin
          if (!hit && free_ok)
          begin
            tbl_reg[base_of(free_idx)] <= i_rx_id[23:16];
            tbl_reg[base_of(free_idx) + 5'h01] <= i_rx_id[15:8];
            tbl_reg[base_of(free_idx) + 5'h02] <= i_rx_id[7:0];
            last_tim_reg <= i_rx_timing;
            rate_reg <= {6'h00, i_rx_rate};
          end
          else if (!hit)
            stat_reg[`SNPC_ST_FULL] <= 1'b1;
        end
        else if (hit || (main_reg[`SNPC_MAIN_AUTO_INS] && free_ok))
        begin
          if (!hit)
          begin
            tbl_reg[base_of(free_idx)] <= i_rx_id[23:16];
            tbl_reg[base_of(free_idx) + 5'h01] <= i_rx_id[15:8];
            tbl_reg[base_of(free_idx) + 5'h02] <= i_rx_id[7:0];
          end
          last_tim_reg <= i_rx_timing;
          pend_id_reg <= i_rx_id;
          o_tx_valid <= 1'b1;
          o_tx_type <= `SNPC_FRM_SYNC;
          o_tx_id <= i_rx_id;
          o_tx_timing <= i_rx_timing;
        end
        else if (main_reg[`SNPC_MAIN_AUTO_INS])
          stat_reg[`SNPC_ST_FULL] <= 1'b1;
        else
        begin
          stat_reg[`SNPC_ST_UNKNOWN] <= 1'b1;
          cand_reg <= i_rx_id;
        end
      end
      if (i_reg_rd)
      begin
        if (shadow_sel && i_reg_addr == `SNPC_ADDR_SHADOW)
          o_reg_rdata <= shadow_reg;
        else if (i_reg_addr >= `SNPC_ADDR_TBL_LO && i_reg_addr <= `SNPC_ADDR_TBL_HI)
          o_reg_rdata <= tbl_reg[tbl_wi];
        else if (i_reg_addr >= `SNPC_ADDR_PAY_LO && i_reg_addr <= `SNPC_ADDR_PAY_HI)
          o_reg_rdata <= pay_reg[i_reg_addr[2:0]];
        else
        begin
          case (i_reg_addr)
            `SNPC_ADDR_MAIN: o_reg_rdata <= main_reg;
            `SNPC_ADDR_TIMER_EN: o_reg_rdata <= timer_en_reg;
            `SNPC_ADDR_LISTEN: o_reg_rdata <= listen_reg;
            `SNPC_ADDR_WAKE_CFG: o_reg_rdata <= wake_cfg_reg;
            `SNPC_ADDR_RATE: o_reg_rdata <= rate_reg;
            `SNPC_ADDR_OWN_ID0: o_reg_rdata <= own_id_reg[23:16];
            `SNPC_ADDR_OWN_ID1: o_reg_rdata <= own_id_reg[15:8];
            `SNPC_ADDR_OWN_ID2: o_reg_rdata <= own_id_reg[7:0];
            `SNPC_ADDR_STATUS: o_reg_rdata <= {3'h0, stat_reg};
            `SNPC_ADDR_CAND0: o_reg_rdata <= cand_reg[23:16];
            `SNPC_ADDR_CAND1: o_reg_rdata <= cand_reg[15:8];
            `SNPC_ADDR_CAND2: o_reg_rdata <= cand_reg[7:0];
            `SNPC_ADDR_LAST_TIM: o_reg_rdata <= last_tim_reg;
            default: o_reg_rdata <= 8'h00;
          endcase
        end
      end
    end
  end
endmodule // snpc_pairing_ctrl

// ---- logic/snpc_defs.vh ----
// Register map, field positions and timing constants of the pairing sequencer.
`ifndef SNPC_DEFS_VH
`define SNPC_DEFS_VH
`define SNPC_ADDR_MAIN 6'h00
`define SNPC_ADDR_TIMER_EN 6'h02
`define SNPC_ADDR_LISTEN 6'h03
`define SNPC_ADDR_WAKE_CFG 6'h04
`define SNPC_ADDR_RATE 6'h06
`define SNPC_ADDR_TBL_LO 6'h08
`define SNPC_ADDR_TBL_HI 6'h1F
`define SNPC_ADDR_SHADOW 6'h0C
`define SNPC_ADDR_OWN_ID0 6'h30
`define SNPC_ADDR_OWN_ID1 6'h31
`define SNPC_ADDR_OWN_ID2 6'h32
`define SNPC_ADDR_STATUS 6'h33
`define SNPC_ADDR_CAND0 6'h34
`define SNPC_ADDR_CAND1 6'h35
`define SNPC_ADDR_CAND2 6'h36
`define SNPC_ADDR_PAY_LO 6'h38
`define SNPC_ADDR_PAY_HI 6'h3C
`define SNPC_ADDR_LAST_TIM 6'h3D
`define SNPC_MAIN_MASTER 0
`define SNPC_MAIN_START 1
`define SNPC_MAIN_WAKE_DET 2
`define SNPC_MAIN_TEMP 3
`define SNPC_MAIN_AUTO_INS 4
`define SNPC_MAIN_SEND 6
`define SNPC_MAIN_SHADOW 7
`define SNPC_LISTEN_EXT 6
`define SNPC_ST_UNKNOWN 0
`define SNPC_ST_PAIRED 1
`define SNPC_ST_FULL 2
`define SNPC_ST_WOKEN 3
`define SNPC_ST_BUSY 4
`define SNPC_FRM_DATA 2'h0
`define SNPC_FRM_SYNC 2'h1
`define SNPC_FRM_ACK 2'h2
`define SNPC_CLK_MHZ 10
`define SNPC_WAKE_LISTEN_US 250
`define SNPC_WAKE_LISTEN_CYC (`SNPC_WAKE_LISTEN_US * `SNPC_CLK_MHZ)
`define SNPC_WAKE_CALL_US 1000000
`define SNPC_WAKE_CALL_CYC (`SNPC_WAKE_CALL_US * `SNPC_CLK_MHZ)
`define SNPC_RX_LISTEN_US 1000000
`define SNPC_RX_LISTEN_CYC (`SNPC_RX_LISTEN_US * `SNPC_CLK_MHZ)
`define SNPC_WAKE_CYC_BASE_US 1000
`define SNPC_WAKE_CYC_BASE_CYC (`SNPC_WAKE_CYC_BASE_US * `SNPC_CLK_MHZ)
`define SNPC_REPLY_WAIT_US 2000
`define SNPC_REPLY_WAIT_CYC (`SNPC_REPLY_WAIT_US * `SNPC_CLK_MHZ)
`endif

// ---- verif/snpc_pairing_chk.sv ----
// Port checker for the pairing sequencer, bound to its top module.
`timescale 1ns/1ps
`include "snpc_defs.vh"
module snpc_pairing_chk #(
  parameter [31:0] WAKE_CALL_CYC = 32'h0000_0028
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_reg_wr,
  input wire [5:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_rx_valid,
  input wire [1:0] i_rx_type,
  input wire [23:0] i_rx_id,
  input wire i_rx_crc_ok,
  input wire o_ook_tx,
  input wire o_rx_enable,
  input wire o_tx_valid,
  input wire [1:0] o_tx_type,
  input wire [23:0] o_tx_id,
  input wire [1:0] o_tx_rate,
  input wire o_unknown_node_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  reg [7:0] cfg_reg;
  reg [7:0] tmr_reg;
  reg [7:0] main_reg;
  reg [31:0] call_reg;
  wire good = i_rx_valid && i_rx_crc_ok && i_rx_type == `SNPC_FRM_DATA;
  wire wr_main = i_reg_wr && i_reg_addr == `SNPC_ADDR_MAIN;
  wire wr_start = wr_main && i_reg_wdata[`SNPC_MAIN_START];
  // Shadows of host writes and a call-length counter, so the checker needs no view inside the design.
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_reg <= 8'h00;
      tmr_reg <= 8'h00;
      main_reg <= 8'h00;
      call_reg <= 32'h0000_0000;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == `SNPC_ADDR_WAKE_CFG)
        cfg_reg <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `SNPC_ADDR_TIMER_EN)
        tmr_reg <= i_reg_wdata;
      if (wr_main)
        main_reg <= i_reg_wdata;
      call_reg <= o_ook_tx ? call_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  property p_start;
    $rose(o_ook_tx) |-> ($past(wr_start) || $past(wr_start, 2)) && tmr_reg == 8'h00;
  endproperty
  a_start: assert property (p_start) else $error("call without start");
  property p_call;
    $fell(o_ook_tx) |-> call_reg == ({30'h0, cfg_reg[1:0]} + 1) * WAKE_CALL_CYC / 4;
  endproperty
  a_call: assert property (p_call) else $error("call length wrong");
  property p_rx_after;
    $fell(o_ook_tx) |-> ##[0:1] o_rx_enable;
  endproperty
  a_rx_after: assert property (p_rx_after) else $error("no listen after call");
  property p_sync;
    o_tx_valid && o_tx_type == `SNPC_FRM_SYNC |-> $past(good) && o_tx_id == $past(i_rx_id);
  endproperty
  a_sync: assert property (p_sync) else $error("sync without frame");
  property p_crc;
    i_rx_valid && !i_rx_crc_ok |=> !o_tx_valid;
  endproperty
  a_crc: assert property (p_crc) else $error("reply to bad frame");
  property p_ack;
    o_tx_valid && o_tx_type == `SNPC_FRM_ACK |-> $past(i_rx_valid && i_rx_type == 2'h1);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without sync");
  property p_rate;
    i_reg_wr && i_reg_addr == `SNPC_ADDR_RATE |-> ##2 o_tx_rate == $past(i_reg_wdata[1:0], 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate not applied");
  property p_temp;
    main_reg[`SNPC_MAIN_TEMP] |-> !o_tx_valid && !o_ook_tx;
  endproperty
  a_temp: assert property (p_temp) else $error("temporary mode sent");
  property p_irq;
    $rose(o_unknown_node_irq) |-> $past(good) || $past(good, 2) || $past(good, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("flag without frame");
  c_sync: cover property (o_tx_valid && o_tx_type == `SNPC_FRM_SYNC);
  c_call: cover property ($fell(o_ook_tx));
  c_irq: cover property ($rose(o_unknown_node_irq));
endmodule // snpc_pairing_chk
bind snpc_pairing_ctrl snpc_pairing_chk #(.WAKE_CALL_CYC(WAKE_CALL_CYC)) i_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_rx_valid(i_rx_valid), .i_rx_type(i_rx_type),
  .i_rx_id(i_rx_id), .i_rx_crc_ok(i_rx_crc_ok), .o_ook_tx(o_ook_tx),
  .o_rx_enable(o_rx_enable), .o_tx_valid(o_tx_valid), .o_tx_type(o_tx_type),
  .o_tx_id(o_tx_id), .o_tx_rate(o_tx_rate), .o_unknown_node_irq(o_unknown_node_irq));

// ---- verif/snpc_peer_model.sv ----
// Peer transceiver model that answers frames and sends frames on request.
`timescale 1ns/1ps
module snpc_peer_model (
  input wire i_clk,
  input wire [7:0] i_dly,
  input wire i_tx_valid,
  input wire [1:0] i_tx_type,
  input wire [23:0] i_tx_id,
  output reg o_valid,
  output reg [1:0] o_type,
  output reg [23:0] o_id,
  output reg [7:0] o_tim,
  output reg o_crc
);
  initial {o_valid, o_type, o_id, o_tim, o_crc} = 36'h0_0000_0000;
  task automatic send(input [1:0] t, input [23:0] id, input [7:0] tm, input c);
    begin
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_type <= t;
      o_id <= id;
      o_tim <= tm;
      o_crc <= c;
      @(posedge i_clk);
      o_valid <= 1'b0;
      // Fields are inverted when idle so a stale frame never looks valid.
      o_id <= ~id;
      o_tim <= ~tm;
      o_crc <= ~c;
    end
  endtask
  always @(posedge i_clk)
  begin
    if (i_tx_valid && i_tx_type != 2'h2)
    begin
      repeat (i_dly) @(posedge i_clk);
      send(i_tx_type + 2'h1, i_tx_id, 8'h00, 1'b1);
    end
  end
endmodule // snpc_peer_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the pairing sequencer.
`timescale 1ns/1ps
`include "snpc_defs.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [5:0] adr = 6'h00;
  reg [7:0] wd = 8'h00;
  reg ook = 1'b0;
  reg [7:0] dly = 8'h02;
  wire [7:0] rdat;
  wire rxv, crc, ookt, wl, rxe, txv, irq;
  wire [1:0] rxt, txt, txr;
  wire [23:0] rxid, txid;
  wire [7:0] rxtm, txtm;
  wire [39:0] txp;
  integer errors = 0;
  integer checked = 0;
  integer ntx = 0;
  integer n0, k;
  reg [7:0] v;
  reg [23:0] w;
  always #50 clk = ~clk;
  always @(posedge clk) if (txv) ntx <= ntx + 1;
  snpc_pairing_ctrl #(.WAKE_CALL_CYC(40), .RX_LISTEN_CYC(200), .WAKE_CYC_BASE(50),
    .REPLY_WAIT_CYC(30)) i_dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(adr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_ook_detect(ook),
    .i_rx_valid(rxv), .i_rx_type(rxt), .i_rx_id(rxid), .i_rx_timing(rxtm),
    .i_rx_rate(2'h1), .i_rx_crc_ok(crc), .o_ook_tx(ookt), .o_wake_listen(wl),
    .o_rx_enable(rxe), .o_tx_valid(txv), .o_tx_type(txt), .o_tx_id(txid),
    .o_tx_timing(txtm), .o_tx_payload(txp), .o_tx_rate(txr), .o_unknown_node_irq(irq));
  snpc_peer_model i_peer (.i_clk(clk), .i_dly(dly), .i_tx_valid(txv), .i_tx_type(txt),
    .i_tx_id(txid), .o_valid(rxv), .o_type(rxt), .o_id(rxid), .o_tim(rxtm), .o_crc(crc));
  task chk(input string nm, input [39:0] seen, input [39:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wreg(input [5:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      adr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [5:0] a, output [7:0] d);
    begin
      @(posedge clk);
      rd <= 1'b1;
      adr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdat;
    end
  endtask
  task creg(input string nm, input [5:0] a, input [7:0] e);
    begin
      rreg(a, v);
      chk(nm, v, e);
    end
  endtask
  task wid(input [5:0] a, input [23:0] id);
    begin
      wreg(a, id[23:16]);
      wreg(a + 6'h01, id[15:8]);
      wreg(a + 6'h02, id[7:0]);
    end
  endtask
  task cid(input string nm, input [5:0] a, input [23:0] e);
    begin
      rreg(a, w[23:16]);
      rreg(a + 6'h01, w[15:8]);
      rreg(a + 6'h02, w[7:0]);
      chk(nm, w, e);
    end
  endtask
  task wtx(input integer n);
    begin
      for (k = 0; k < 400 && ntx < n; k = k + 1) @(posedge clk);
      @(negedge clk);
    end
  endtask
  // Frames sent with the receiver off would be ignored, so wait on the enable.
  task wrx(input val);
    begin
      for (k = 0; k < 1000 && rxe !== val; k = k + 1) @(posedge clk);
    end
  endtask
  task frame(input [23:0] id, input [7:0] tm, input c);
    begin
      n0 = ntx;
      i_peer.send(`SNPC_FRM_DATA, id, tm, c);
    end
  endtask
  task report_and_stop;
    begin
      if (errors == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    errors = errors + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    creg("main", `SNPC_ADDR_MAIN, 8'h00);
    cid("table", `SNPC_ADDR_TBL_HI - 6'h02, 24'h00_0000);
    creg("hole", 6'h3F, 8'h00);
    wreg(`SNPC_ADDR_RATE, 8'h02);
    creg("rate", `SNPC_ADDR_RATE, 8'h02);
    chk("tx rate", txr, 2'h2);
    wreg(`SNPC_ADDR_WAKE_CFG, 8'h1C);
    creg("wake cfg", `SNPC_ADDR_WAKE_CFG, 8'h1C);
    wreg(`SNPC_ADDR_MAIN, 8'h04);
    for (k = 0; k < 8000 && !wl; k = k + 1) @(posedge clk);
    chk("listen", wl, 1'b1);
    for (k = 0; wl && k < 3000; k = k + 1) @(posedge clk);
    chk("window", k, 2500);
    ook <= 1'b1;
    for (k = 0; k < 8000 && !wl; k = k + 1) @(posedge clk);
    chk("interval", k, 6400);
    repeat (20) @(posedge clk);
    ook <= 1'b0;
    repeat (5) @(posedge clk);
    rreg(`SNPC_ADDR_STATUS, v);
    chk("woken", v[`SNPC_ST_WOKEN], 1'b1);
    wreg(`SNPC_ADDR_MAIN, 8'h00);
    wreg(`SNPC_ADDR_WAKE_CFG, 8'h00);
    wreg(`SNPC_ADDR_TIMER_EN, 8'h00);
    wreg(`SNPC_ADDR_LISTEN, 8'h40);
    wid(6'h08, 24'h00_0010);
    wid(6'h0E, 24'h00_0030);
    wreg(`SNPC_ADDR_MAIN, 8'h13);
    for (k = 0; k < 100 && !ookt; k = k + 1) @(posedge clk);
    for (k = 0; ookt && k < 100; k = k + 1) @(posedge clk);
    chk("call", k, 10);
    @(negedge clk);
    chk("rx on", rxe, 1'b1);
    frame(24'h00_0010, 8'h21, 1'b1);
    wtx(n0 + 1);
    chk("sync", {txt, txid}, {`SNPC_FRM_SYNC, 24'h00_0010});
    repeat (20) @(posedge clk);
    rreg(`SNPC_ADDR_STATUS, v);
    chk("done", v[`SNPC_ST_PAIRED], 1'b1);
    frame(24'hAB_CDEF, 8'h21, 1'b1);
    wtx(n0 + 1);
    chk("sync new", {txt, txid}, {`SNPC_FRM_SYNC, 24'hAB_CDEF});
    repeat (20) @(posedge clk);
    cid("slot", 6'h0B, 24'hAB_CDEF);
    frame(24'hAB_CDEF, 8'h21, 1'b1);
    repeat (40) @(posedge clk);
    frame(24'h12_3456, 8'h21, 1'b0);
    frame(24'h00_0030, 8'h21, 1'b0);
    repeat (40) @(posedge clk);
    chk("bad crc", ntx, n0);
    cid("dup", 6'h11, 24'h00_0000);
    for (n0 = 3; n0 < 8; n0 = n0 + 1) wid(6'(8 + 3 * n0), 24'(256 + n0));
    frame(24'h77_7777, 8'h21, 1'b1);
    repeat (40) @(posedge clk);
    chk("full", ntx, n0);
    cid("kept", 6'h1D, 24'h00_0107);
    wreg(`SNPC_ADDR_LISTEN, 8'h00);
    wrx(1'b0);
    chk("listen end", rxe, 1'b0);
    wreg(`SNPC_ADDR_MAIN, 8'h03);
    wrx(1'b1);
    wreg(`SNPC_ADDR_STATUS, 8'hFF);
    frame(24'h00_ABCD, 8'h21, 1'b1);
    repeat (5) @(posedge clk);
    chk("flag", irq, 1'b1);
    cid("cand", `SNPC_ADDR_CAND0, 24'h00_ABCD);
    chk("no ack", ntx, n0);
    wreg(`SNPC_ADDR_STATUS, 8'h01);
    repeat (3) @(posedge clk);
    chk("cleared", irq, 1'b0);
    wrx(1'b0);
    wid(`SNPC_ADDR_OWN_ID0, 24'h5A_1234);
    for (n0 = 0; n0 < 5; n0 = n0 + 1) wreg(6'(56 + n0), 8'(17 * (n0 + 1)));
    wreg(`SNPC_ADDR_MAIN, 8'h80);
    wreg(`SNPC_ADDR_SHADOW, 8'hA7);
    wreg(`SNPC_ADDR_MAIN, 8'h00);
    dly <= 8'h14;
    n0 = ntx;
    wreg(`SNPC_ADDR_MAIN, 8'h40);
    wtx(n0 + 1);
    chk("data", {txt, txid, txtm}, {2'h0, 24'h5A_1234, 8'hA7});
    chk("payload", txp, 40'h11_2233_4455);
    wtx(n0 + 2);
    chk("ack", {txt, txid}, {`SNPC_FRM_ACK, 24'h5A_1234});
    rreg(`SNPC_ADDR_STATUS, v);
    chk("client paired", v[`SNPC_ST_PAIRED], 1'b1);
    wrx(1'b0);
    wid(6'h1D, 24'h00_0000);
    wreg(`SNPC_ADDR_MAIN, 8'h1B);
    wrx(1'b1);
    frame(24'h44_4444, 8'h65, 1'b1);
    repeat (40) @(posedge clk);
    chk("silent", ntx, n0);
    cid("temp", 6'h1D, 24'h44_4444);
    creg("timing", `SNPC_ADDR_LAST_TIM, 8'h65);
    creg("adopt rate", `SNPC_ADDR_RATE, 8'h01);
    report_and_stop;
  end
endmodule // tb_top
